// [rtl/swtl_pkg.sv]
/*
 * Shared constants for the wakeup timer and undervoltage control slice:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 100 MHz core clock and an 8-bit register port.
 */
package swtl_pkg;
    // Register offsets on the 3-bit register address
    localparam logic [2:0] ADR_PN_HIGH = 3'h0;
    localparam logic [2:0] ADR_PN_LOW = 3'h1;
    localparam logic [2:0] ADR_WAKEUP = 3'h2;
    localparam logic [2:0] ADR_POWER = 3'h3;

    // Part number, value arbitrary
    localparam logic [11:0] PART_NUMBER = 12'h5A3;

    // Wakeup register fields
    localparam int WK_FLAG_BIT = 7;
    localparam int WK_CLEAR_BIT = 6;
    localparam int WK_CLKSEL_BIT = 5;
    localparam int WK_IRQEN_BIT = 4;
    localparam int WK_DELAY_LSB = 0;

    // Power monitor register fields
    localparam int UV_FLAG_BIT = 7;
    localparam int UV_CLEAR_BIT = 6;
    localparam int UV_IRQEN_BIT = 5;
    localparam int UV_RSTEN_BIT = 4;
    localparam int UV_STOPEN_BIT = 3;
    localparam int UV_ENABLE_BIT = 2;
    localparam int UV_REFBUF_BIT = 0;

    // Reset values of the writable fields
    localparam logic [2:0] WK_DELAY_RESET = 3'h0;
    localparam logic WK_CLKSEL_RESET = 1'b0;
    localparam logic WK_IRQEN_RESET = 1'b0;
    localparam logic [4:0] UV_CTRL_RESET = 5'h00;

    // Internal oscillator period and its cycle count at the core rate
    localparam int CORE_CLK_PERIOD_NS = 10;
    localparam int OSC_PERIOD_NS = 1000000;
    localparam int OSC_CYCLES = OSC_PERIOD_NS / CORE_CLK_PERIOD_NS;

    // Wakeup periods in oscillator ticks, codes 1 to 7
    localparam int INT_PERIOD_1 = 8;
    localparam int INT_PERIOD_2 = 32;
    localparam int INT_PERIOD_3 = 64;
    localparam int INT_PERIOD_4 = 128;
    localparam int INT_PERIOD_5 = 256;
    localparam int INT_PERIOD_6 = 512;
    localparam int INT_PERIOD_7 = 1024;
    // Wakeup periods in crystal edges, codes 1 to 7
    localparam int EXT_PERIOD_1 = 256;
    localparam int EXT_PERIOD_2 = 1024;
    localparam int EXT_PERIOD_3 = 2048;
    localparam int EXT_PERIOD_4 = 4096;
    localparam int EXT_PERIOD_5 = 8192;
    localparam int EXT_PERIOD_6 = 16384;
    localparam int EXT_PERIOD_7 = 32768;
endpackage

// [rtl/swtl_wk_if.sv]
/*
 * Carrier between the register slice and the wakeup period counter.
 * Assumes both ends run on the core clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface swtl_wk_if;
    logic int_tick;
    logic ext_tick;
    logic clk_sel;
    logic [2:0] delay_sel;
    logic timeout;
    modport ctl (output int_tick, ext_tick, clk_sel, delay_sel,
                 input timeout);
    modport tmr (input int_tick, ext_tick, clk_sel, delay_sel,
                 output timeout);
endinterface
`default_nettype wire

// [rtl/swtl_wakeup_counter.sv]
/*
 * Periodic wakeup counter: counts ticks of the selected source and
 * pulses timeout once per selected period.
 * Assumes ticks are one-cycle enables on the core clock.
 */
`timescale 1ns/100ps
`default_nettype none
module swtl_wakeup_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Controls and timeout
    swtl_wk_if.tmr wk
);
    logic [14:0] count;
    logic [2:0] last_sel;
    logic last_clk;
    logic tick;
    logic restart;
    logic [14:0] last_count;

    // Last count of one period for a source and delay code
    function automatic logic [14:0] period_last(input logic ext,
                                                input logic [2:0] sel);
        int p;
        p = 1;
        case (sel)
            3'h1: p = ext ? swtl_pkg::EXT_PERIOD_1 : swtl_pkg::INT_PERIOD_1;
            3'h2: p = ext ? swtl_pkg::EXT_PERIOD_2 : swtl_pkg::INT_PERIOD_2;
            3'h3: p = ext ? swtl_pkg::EXT_PERIOD_3 : swtl_pkg::INT_PERIOD_3;
            3'h4: p = ext ? swtl_pkg::EXT_PERIOD_4 : swtl_pkg::INT_PERIOD_4;
            3'h5: p = ext ? swtl_pkg::EXT_PERIOD_5 : swtl_pkg::INT_PERIOD_5;
            3'h6: p = ext ? swtl_pkg::EXT_PERIOD_6 : swtl_pkg::INT_PERIOD_6;
            3'h7: p = ext ? swtl_pkg::EXT_PERIOD_7 : swtl_pkg::INT_PERIOD_7;
            default: p = 1;
        endcase
        return 15'(p - 1);
    endfunction

    // Source select and change detection
    assign tick = wk.clk_sel ? wk.ext_tick : wk.int_tick;
    assign restart = (wk.delay_sel != last_sel) || (wk.clk_sel != last_clk);
    assign last_count = period_last(wk.clk_sel, wk.delay_sel);

    // Remember the settings the count was started under
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_sel <= swtl_pkg::WK_DELAY_RESET;
            last_clk <= swtl_pkg::WK_CLKSEL_RESET;
        end else begin
            last_sel <= wk.delay_sel;
            last_clk <= wk.clk_sel;
        end
    end

    // Period counter with timeout pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 15'h0000;
            wk.timeout <= 1'b0;
        end else if (restart || wk.delay_sel == 3'h0) begin
            count <= 15'h0000;
            wk.timeout <= 1'b0;
        end else if (tick && count == last_count) begin
            count <= 15'h0000;
            wk.timeout <= 1'b1;
        end else begin
            count <= tick ? count + 15'h0001 : count;
            wk.timeout <= 1'b0;
        end
    end

    a_timer_stopped: assert property (@(posedge clk) disable iff (!rst_n)
        wk.delay_sel == 3'h0 |=> !wk.timeout)
        else $error("Timeout with wakeup timer stopped");
    a_restart_zero: assert property (@(posedge clk) disable iff (!rst_n)
        restart |=> count == 15'h0000 && !wk.timeout)
        else $error("Counter did not restart on setting change");
    a_period_end: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(wk.timeout) |-> $past(count) == $past(last_count)
        && $past(tick))
        else $error("Timeout not at end of selected period");
endmodule // swtl_wakeup_counter
`default_nettype wire

// [rtl/swtl_top.sv]
/*
 * System slice: part number, periodic wakeup timer control and the
 * undervoltage detect control register, on a plain 8-bit register port.
 * Assumes a 100 MHz core clock; crystal and detector inputs are pins
 * from outside the clock domain; stop mode comes from core logic.
 */
`timescale 1ns/100ps
`default_nettype none
module swtl_top #(
    parameter int OSC_DIV = swtl_pkg::OSC_CYCLES
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // Register port
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RD_DATA,
    // Pins and core inputs
    input wire logic XTAL_CLK,
    input wire logic UNDERVOLT_IN,
    input wire logic STOP_MODE,
    // System outputs
    output logic WAKEUP_IRQ,
    output logic UNDERVOLT_IRQ,
    output logic UNDERVOLT_RESET,
    output logic UNDERVOLT_DETECT_ON,
    output logic REF_BUFFER_EN
);
    swtl_wk_if wk ();

    logic [16:0] osc_count;
    logic osc_tick;
    logic xtal_s1;
    logic xtal_s2;
    logic xtal_prev;
    logic uv_s1;
    logic uv_s2;
    logic wk_flag;
    logic wk_clk_sel;
    logic wk_irq_en;
    logic [2:0] wk_delay;
    logic uv_flag;
    logic uv_irq_en;
    logic uv_rst_en;
    logic uv_stop_en;
    logic uv_enable;
    logic ref_buf;
    logic wr_wake;
    logic wr_power;
    logic wk_clear;
    logic uv_clear;
    logic uv_set;
    logic detect_active;
    logic [7:0] next_rd_data;

    // Write strobe aimed at one register
    function automatic logic write_hit(input logic wr, input logic [2:0] a,
                                       input logic [2:0] target);
        return wr && a == target;
    endfunction

    // Write decode
    assign wr_wake = write_hit(WR, ADDR, swtl_pkg::ADR_WAKEUP);
    assign wr_power = write_hit(WR, ADDR, swtl_pkg::ADR_POWER);
    assign wk_clear = wr_wake && WR_DATA[swtl_pkg::WK_CLEAR_BIT];
    assign uv_clear = wr_power && WR_DATA[swtl_pkg::UV_CLEAR_BIT];

    // Free-running internal oscillator tick from the core clock
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            osc_count <= 17'h00000;
            osc_tick <= 1'b0;
        end else if (osc_count == 17'(OSC_DIV - 1)) begin
            osc_count <= 17'h00000;
            osc_tick <= 1'b1;
        end else begin
            osc_count <= osc_count + 17'h00001;
            osc_tick <= 1'b0;
        end
    end

    // Crystal pin synchroniser and rising edge detect
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            xtal_s1 <= 1'b0;
            xtal_s2 <= 1'b0;
            xtal_prev <= 1'b0;
        end else begin
            xtal_s1 <= XTAL_CLK;
            xtal_s2 <= xtal_s1;
            xtal_prev <= xtal_s2;
        end
    end

    // Detector pin synchroniser
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            uv_s1 <= 1'b0;
            uv_s2 <= 1'b0;
        end else begin
            uv_s1 <= UNDERVOLT_IN;
            uv_s2 <= uv_s1;
        end
    end

    // Hand the selected settings and ticks to the period counter
    assign wk.int_tick = osc_tick;
    assign wk.ext_tick = xtal_s2 && !xtal_prev;
    assign wk.clk_sel = wk_clk_sel;
    assign wk.delay_sel = wk_delay;

    swtl_wakeup_counter u_counter (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .wk(wk.tmr)
    );

    // Wakeup control fields
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wk_clk_sel <= swtl_pkg::WK_CLKSEL_RESET;
            wk_irq_en <= swtl_pkg::WK_IRQEN_RESET;
            wk_delay <= swtl_pkg::WK_DELAY_RESET;
        end else if (wr_wake) begin
            wk_clk_sel <= WR_DATA[swtl_pkg::WK_CLKSEL_BIT];
            wk_irq_en <= WR_DATA[swtl_pkg::WK_IRQEN_BIT];
            wk_delay <= WR_DATA[swtl_pkg::WK_DELAY_LSB +: 3];
        end
    end

    // Wakeup flag: timeout wins over a clear in the same cycle
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wk_flag <= 1'b0;
        end else if (wk.timeout) begin
            wk_flag <= 1'b1;
        end else if (wk_clear) begin
            wk_flag <= 1'b0;
        end
    end

    // Power monitor control fields, bit 1 kept at zero
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            {uv_irq_en, uv_rst_en, uv_stop_en, uv_enable, ref_buf} <=
                swtl_pkg::UV_CTRL_RESET;
        end else if (wr_power) begin
            uv_irq_en <= WR_DATA[swtl_pkg::UV_IRQEN_BIT];
            uv_rst_en <= WR_DATA[swtl_pkg::UV_RSTEN_BIT];
            uv_stop_en <= WR_DATA[swtl_pkg::UV_STOPEN_BIT];
            uv_enable <= WR_DATA[swtl_pkg::UV_ENABLE_BIT];
            ref_buf <= WR_DATA[swtl_pkg::UV_REFBUF_BIT];
        end
    end

    // Detector runs when enabled, and in stop only if allowed
    assign detect_active = uv_enable && (!STOP_MODE || uv_stop_en);
    assign uv_set = uv_s2 && detect_active;

    // Undervoltage flag: detect wins over a clear in the same cycle
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            uv_flag <= 1'b0;
        end else if (uv_set) begin
            uv_flag <= 1'b1;
        end else if (uv_clear) begin
            uv_flag <= 1'b0;
        end
    end

    // Detector power enable to the analog side
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            UNDERVOLT_DETECT_ON <= 1'b0;
        end else begin
            UNDERVOLT_DETECT_ON <= detect_active;
        end
    end

    // Requests follow their flags while enabled
    assign WAKEUP_IRQ = wk_flag && wk_irq_en;
    assign UNDERVOLT_IRQ = uv_flag && uv_irq_en && uv_enable;
    assign UNDERVOLT_RESET = uv_flag && uv_rst_en && uv_enable;
    assign REF_BUFFER_EN = ref_buf;

    // Read mux; reserved, write-only and unmapped bits read zero
    always_comb begin
        next_rd_data = 8'h00;
        case (ADDR)
            swtl_pkg::ADR_PN_HIGH: begin
                next_rd_data = {4'h0, swtl_pkg::PART_NUMBER[11:8]};
            end
            swtl_pkg::ADR_PN_LOW: begin
                next_rd_data = swtl_pkg::PART_NUMBER[7:0];
            end
            swtl_pkg::ADR_WAKEUP: begin
                next_rd_data = {wk_flag, 1'b0, wk_clk_sel, wk_irq_en,
                                1'b0, wk_delay};
            end
            swtl_pkg::ADR_POWER: begin
                next_rd_data = {uv_flag, 1'b0, uv_irq_en, uv_rst_en,
                                uv_stop_en, uv_enable, 1'b0, ref_buf};
            end
            default: begin
                next_rd_data = 8'h00;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            RD_DATA <= 8'h00;
        end else begin
            RD_DATA <= RD ? next_rd_data : 8'h00;
        end
    end

    a_part_number: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        RD && ADDR == swtl_pkg::ADR_PN_LOW
        |=> RD_DATA == swtl_pkg::PART_NUMBER[7:0])
        else $error("Part number low read wrong");
    a_part_high: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        RD && ADDR == swtl_pkg::ADR_PN_HIGH
        |=> RD_DATA[3:0] == swtl_pkg::PART_NUMBER[11:8])
        else $error("Part number high read wrong");
    a_wake_flag_set: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        wk.timeout |=> wk_flag ##1 (RD_DATA[7] || !$past(RD)
        || $past(ADDR) != swtl_pkg::ADR_WAKEUP))
        else $error("Wakeup flag not set by timeout");
    a_wake_clear: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        wk_clear && !wk.timeout |=> !wk_flag)
        else $error("Wakeup flag not cleared");
    a_wake_read_zero: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        RD && ADDR == swtl_pkg::ADR_WAKEUP
        |=> RD_DATA[6] == 1'b0 && RD_DATA[3] == 1'b0
        && RD_DATA[7] == $past(wk_flag))
        else $error("Wakeup register read wrong");
    a_flag_hold: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        wk_flag && !wk_clear |=> wk_flag ##0 (WAKEUP_IRQ == wk_irq_en))
        else $error("Wakeup flag dropped without clear");
    a_uv_gated: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !uv_flag && !uv_enable |=> !uv_flag)
        else $error("Undervoltage flag set while disabled");
    a_uv_clear: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        uv_clear && !uv_set |=> !uv_flag && !UNDERVOLT_RESET)
        else $error("Undervoltage flag not cleared");
    a_uv_reset: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        UNDERVOLT_RESET |-> uv_flag && uv_rst_en && uv_enable)
        else $error("Reset request without cause");
    a_stop_off: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        STOP_MODE && !uv_stop_en |=> !UNDERVOLT_DETECT_ON)
        else $error("Detector running in stop when not allowed");
    a_refbuf_write: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        wr_power |=> REF_BUFFER_EN == $past(WR_DATA[0]))
        else $error("Reference buffer enable not written");

    // Wakeup field, flag, request and oscillator tick checks
    a_wake_fields: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        wr_wake |=> wk_clk_sel == $past(WR_DATA[5])
        && wk_irq_en == $past(WR_DATA[4]) && wk_delay == $past(WR_DATA[2:0]))
        else $error("Wakeup control fields not written");
    a_wake_irq_off: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !wk_irq_en |-> !WAKEUP_IRQ)
        else $error("Wakeup request while disabled");
    a_wake_irq_on: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        wk_flag && wk_irq_en |-> WAKEUP_IRQ)
        else $error("Wakeup request missing");
    a_wake_set_wins: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        wk.timeout && wk_clear |=> wk_flag)
        else $error("Clear beat a timeout");
    a_irq_cleared: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        wk_clear && !wk.timeout |=> !WAKEUP_IRQ)
        else $error("Wakeup request stayed after clear");
    a_osc_tick: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        osc_tick |-> osc_count == 17'h00000)
        else $error("Oscillator tick off its count");

    // Undervoltage flag checks
    a_uv_set: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        uv_set |=> uv_flag)
        else $error("Undervoltage flag not set");
    a_uv_set_wins: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        uv_set && uv_clear |=> uv_flag)
        else $error("Clear beat a detect event");
    a_uv_hold: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        uv_flag && !uv_clear |=> uv_flag)
        else $error("Undervoltage flag dropped without clear");
    a_power_read: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        RD && ADDR == swtl_pkg::ADR_POWER |=> RD_DATA[6] == 1'b0
        && RD_DATA[1] == 1'b0 && RD_DATA[7] == $past(uv_flag))
        else $error("Power monitor register read wrong");

    // Undervoltage request gating and detector power checks
    a_uv_irq_gate: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !uv_enable |-> !UNDERVOLT_IRQ && !UNDERVOLT_RESET)
        else $error("Request while detector disabled");
    a_uv_irq_off: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !uv_irq_en |-> !UNDERVOLT_IRQ)
        else $error("Undervoltage request while disabled");
    a_uv_reset_off: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !uv_rst_en |-> !UNDERVOLT_RESET)
        else $error("Reset request while disabled");
    a_detect_off: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !uv_enable |=> !UNDERVOLT_DETECT_ON)
        else $error("Detector on while disabled");

    c_wake_timeout: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
        WAKEUP_IRQ);
    c_clear_race: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
        wk.timeout && wk_clear);
    c_uv_flag: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
        $rose(uv_flag));
    c_uv_reset: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
        UNDERVOLT_RESET);
    c_stop_run: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
        STOP_MODE && UNDERVOLT_DETECT_ON);
endmodule // swtl_top
`default_nettype wire

// [tb/swtl_top_bench.sv]
/*
 * Self-checking bench for the wakeup timer and undervoltage slice.
 * Assumes the top module at a shortened oscillator divider and a bench
 * made crystal clock of eight core cycles per period.
 */
`timescale 1ns/100ps
`default_nettype none
module swtl_top_bench;
    localparam int OSC = 10;
    localparam int XP = 8;
    localparam int LIMIT = 90000;
    logic core_clk, rstn, wr, rd, xtal, uv_in, stop, xtal_run;
    logic [2:0] addr;
    logic [7:0] wr_data, rd_data;
    logic wk_irq, uv_irq, uv_rst, uv_on, ref_en;
    int n_fail, check_count, cyc, xdiv;
    int int_ticks[7] = '{8, 32, 64, 128, 256, 512, 1024};

    swtl_top #(.OSC_DIV(OSC)) u_swtl_top (
        .CORE_CLK(core_clk), .RSTN(rstn), .ADDR(addr), .WR_DATA(wr_data),
        .WR(wr), .RD(rd), .RD_DATA(rd_data), .XTAL_CLK(xtal),
        .UNDERVOLT_IN(uv_in), .STOP_MODE(stop), .WAKEUP_IRQ(wk_irq),
        .UNDERVOLT_IRQ(uv_irq), .UNDERVOLT_RESET(uv_rst),
        .UNDERVOLT_DETECT_ON(uv_on), .REF_BUFFER_EN(ref_en));

    // Core clock, 10 ns period
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Crystal clock, runs only while a crystal scenario needs it
    always @(posedge core_clk) begin
        if (xtal_run) begin
            xdiv <= (xdiv == XP / 2 - 1) ? 0 : xdiv + 1;
            if (xdiv == XP / 2 - 1) xtal <= ~xtal;
        end
    end

    // Hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            $display("[ERR] %0t: run exceeded cycle ceiling", $time);
            conclude();
        end
    end

    // Compare one value against its expectation
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle register write
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        #1;
    endtask

    // One-cycle register read, data taken in the following cycle
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        d = rd_data;
    endtask

    // Read and compare
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        reg_rd(a, d);
        check(d, exp);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Identification, read-only places and unmapped reads
    task automatic t_ident;
        logic [7:0] d;
        rd_chk(3'h1, swtl_pkg::PART_NUMBER[7:0]);
        reg_rd(3'h0, d);
        check({4'h0, d[3:0]}, {4'h0, swtl_pkg::PART_NUMBER[11:8]});
        @(posedge core_clk);
        #1;
        check(rd_data, 8'h00);
        reg_wr(3'h0, 8'hFF);
        reg_wr(3'h1, 8'h00);
        rd_chk(3'h1, swtl_pkg::PART_NUMBER[7:0]);
        reg_rd(3'h0, d);
        check({4'h0, d[3:0]}, {4'h0, swtl_pkg::PART_NUMBER[11:8]});
        rd_chk(3'h5, 8'h00);
        rd_chk(3'h2, 8'h00);
        rd_chk(3'h3, 8'h00);
    endtask

    // Program a period, time the request, then acknowledge it
    task automatic wk_period(input logic [7:0] ctl, input int n, input int u);
        int k;
        k = 0;
        reg_wr(3'h2, ctl);
        while (wk_irq !== 1'b1 && k < n * u + 20) begin
            cycles(1);
            k++;
        end
        check((k >= (n - 1) * u && k <= n * u + 8), 1'b1);
        cycles(5);
        rd_chk(3'h2, ctl | 8'h80);
        reg_wr(3'h2, ctl);
        rd_chk(3'h2, ctl | 8'h80);
        reg_wr(3'h2, ctl | 8'h40);
        check(wk_irq, 1'b0);
        rd_chk(3'h2, ctl);
    endtask

    // Every internal delay code, with a mid-period code change first
    task automatic t_wk_internal;
        reg_wr(3'h2, 8'h11);
        cycles(60);
        wk_period(8'h12, 32, OSC);
        for (int c = 1; c <= 7; c++) wk_period(8'h10 | 8'(c), int_ticks[c - 1], OSC);
    endtask

    // Crystal source, first three divide codes
    task automatic t_wk_crystal;
        xtal_run <= 1'b1;
        wk_period(8'h31, 256, XP);
        wk_period(8'h32, 1024, XP);
        wk_period(8'h33, 2048, XP);
        xtal_run <= 1'b0;
    endtask

    // Stopped timer, and flag without request enable
    task automatic t_wk_stop_irqen;
        reg_wr(3'h2, 8'h10);
        cycles(1500);
        check(wk_irq, 1'b0);
        rd_chk(3'h2, 8'h10);
        reg_wr(3'h2, 8'h01);
        cycles(100);
        check(wk_irq, 1'b0);
        rd_chk(3'h2, 8'h81);
        reg_wr(3'h2, 8'h10);
        check(wk_irq, 1'b1);
        reg_wr(3'h2, 8'h50);
        check(wk_irq, 1'b0);
    endtask

    // Wait a few cycles for the undervoltage request
    task automatic wait_uv;
        int k;
        k = 0;
        while (uv_irq !== 1'b1 && k < 8) begin
            cycles(1);
            k++;
        end
    endtask

    // Undervoltage flag, gating, acknowledge, stop mode and buffer enable
    task automatic t_uv;
        reg_wr(3'h3, 8'h30);
        uv_in <= 1'b1;
        cycles(10);
        check({uv_irq, uv_rst, uv_on}, 3'b000);
        rd_chk(3'h3, 8'h30);
        reg_wr(3'h3, 8'h34);
        wait_uv();
        check({uv_irq, uv_rst, uv_on}, 3'b111);
        rd_chk(3'h3, 8'hB4);
        uv_in <= 1'b0;
        cycles(6);
        rd_chk(3'h3, 8'hB4);
        reg_wr(3'h3, 8'h74);
        check({uv_irq, uv_rst}, 2'b00);
        rd_chk(3'h3, 8'h34);
        reg_wr(3'h3, 8'h24);
        uv_in <= 1'b1;
        wait_uv();
        check({uv_irq, uv_rst}, 2'b10);
        uv_in <= 1'b0;
        cycles(6);
        reg_wr(3'h3, 8'h64);
        stop <= 1'b1;
        cycles(3);
        check(uv_on, 1'b0);
        uv_in <= 1'b1;
        cycles(8);
        check(uv_irq, 1'b0);
        uv_in <= 1'b0;
        cycles(4);
        reg_wr(3'h3, 8'h2C);
        cycles(2);
        check(uv_on, 1'b1);
        uv_in <= 1'b1;
        wait_uv();
        check(uv_irq, 1'b1);
        uv_in <= 1'b0;
        stop <= 1'b0;
        cycles(4);
        // Reserved bit 1 is always written as zero
        reg_wr(3'h3, 8'h6C);
        reg_wr(3'h3, 8'h01);
        cycles(2);
        check({uv_irq, uv_on, ref_en}, 3'b001);
        rd_chk(3'h3, 8'h01);
        reg_wr(3'h3, 8'h00);
        check(ref_en, 1'b0);
    endtask

    // Reset in mid-run returns every field to zero
    task automatic t_reset;
        reg_wr(3'h3, 8'h35);
        reg_wr(3'h2, 8'h37);
        @(posedge core_clk);
        rstn <= 1'b0;
        cycles(3);
        check({uv_on, ref_en, wk_irq}, 3'b000);
        rstn <= 1'b1;
        rd_chk(3'h3, 8'h00);
        rd_chk(3'h2, 8'h00);
    endtask

    // Verdict and end of run
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {rstn, wr, rd, xtal, uv_in, stop, xtal_run} = 7'h00;
        addr = 3'h0;
        wr_data = 8'h00;
        n_fail = 0;
        check_count = 0;
        cyc = 0;
        xdiv = 0;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        t_ident();
        t_wk_stop_irqen();
        t_wk_internal();
        t_wk_crystal();
        t_uv();
        t_reset();
        conclude();
    end
endmodule // swtl_top_bench
`default_nettype wire
